//--- pkg/sync_tx_regs.vh
`ifndef SYNC_TX_REGS_VH
`define SYNC_TX_REGS_VH
// register addresses
`define ADDR_TX_STATUS_CONTROL 8'h00
`define ADDR_RX_STATUS_CONTROL 8'h01
`define ADDR_TX_HOLDING 8'h02
`define ADDR_BAUD_DIVISOR 8'h03
`define ADDR_IRQ_FLAG 8'h04
`define ADDR_IRQ_ENABLE 8'h05
`define ADDR_RX_DATA 8'h06
// transmit status/control fields
`define TXC_CLOCK_SOURCE 7
`define TXC_NINTH_SELECT 6
`define TXC_TX_ENABLE 5
`define TXC_SYNC_MODE 4
`define TXC_SHIFT_EMPTY 1
`define TXC_NINTH_VALUE 0
// receive status/control fields
`define RXC_PORT_ENABLE 7
`define RXC_SINGLE_RX 5
`define RXC_CONT_RX 4
// flag and enable fields
`define IRQ_TX_FLAG 1
`define IRQ_RX_FLAG 0
// reset values
`define RST_TX_STATUS_CONTROL 8'h02
`define RST_RX_STATUS_CONTROL 8'h00
`define RST_BAUD_DIVISOR 8'h00
`endif

//--- hdl/sync_tx_bitsync.v
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module sync_tx_bitsync
(
    input wire core_clk,
    input wire reset_n,
    input wire async_in,
    output reg sync_out
);
reg meta_r;
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        meta_r <= 1'b0;
        sync_out <= 1'b0;
    end
    else
    begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end
endmodule
`default_nettype wire

//--- hdl/usart_sync_master_tx.v
// Summary of operation
// - never transmit and receive at once; each direction inhibits the other
// - sync mode bit 4 of transmit control selects synchronous operation
// - port enable bit 7 of receive control claims clock and data pins
// - clock source bit 7 of transmit control makes us master driving clock
// - shift register reloads only after the last bit, at once if data waits
// - transfer at end of baud cycle empties buffer and sets flag bit 1
// - transmit flag sets regardless of its enable; enable only gates request
// - transmit flag ignores software writes; clears only on buffer write
// - shift empty status bit 1 is read only, no interrupt
// - shift register is not reachable through the register map
// - transmit enable bit 5 allows sending; nothing shifts until buffer loaded
// - data changes on rising clock edge, stable around falling edge
// - baud generator held in reset while all enables clear
// - clearing transmit enable aborts, resets transmitter, floats data pin, and clock pin unless a receive enable is set
// - receive enable aborts send, floats data, keeps master clock, no reset
// - single receive clears itself after one word; it samples only while transmit enable is clear
// - ninth bit captured from bit 0 at transfer when nine-bit selected
// - clearing port enable or transmit enable resets transmit logic
`include "sync_tx_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module usart_sync_master_tx
(
    input wire core_clk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire shift_strobe_line_in,
    output reg shift_strobe_line_out,
    output reg shift_strobe_line_oe,
    input wire serial_data_line_in,
    output reg serial_data_line_out,
    output reg serial_data_line_oe,
    output reg transmit_irq_request
);
// ----------------------------------------
// registers
// ----------------------------------------
reg clock_source_select_r;
reg ninth_bit_transmit_select_r;
reg transmit_enable_r;
reg sync_mode_r;
reg ninth_transmit_bit_value_r;
reg serial_port_enable_r;
reg single_receive_enable_r;
reg continuous_receive_enable_r;
reg [7:0] baud_divisor_r;
reg transmit_interrupt_enable_r;
reg [7:0] transmit_holding_buffer_r;
reg holding_full_r;
reg [8:0] transmit_shift_register_r;
reg [3:0] bits_left_r;
reg [7:0] rx_shift_r;
reg [3:0] rx_count_r;
reg [7:0] rx_data_r;
reg rx_flag_r;
reg [7:0] baud_cnt_r;
reg phase_r;
wire data_sync;
wire clk_sync;
// ----------------------------------------
// pin input synchronisers
// ----------------------------------------
sync_tx_bitsync u_data_sync
(
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(serial_data_line_in),
    .sync_out(data_sync)
);
sync_tx_bitsync u_clk_sync
(
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(shift_strobe_line_in),
    .sync_out(clk_sync)
);
// ----------------------------------------
// mode decode
// ----------------------------------------
wire receiving = continuous_receive_enable_r | single_receive_enable_r;
wire master = sync_mode_r & serial_port_enable_r & clock_source_select_r;
wire tx_reset = ~transmit_enable_r | ~serial_port_enable_r;
wire baud_run = transmit_enable_r | receiving;
wire baud_tick = baud_run & (baud_cnt_r == 8'h00);
// clock output is ~phase_r, so phase going 1 to 0 is its rising edge
wire rise_tick = baud_tick & phase_r;
wire fall_tick = baud_tick & ~phase_r;
wire tx_active = ~tx_reset & ~receiving & master;
// ----------------------------------------
// transmit sequencing
// ----------------------------------------
wire shift_empty = (bits_left_r == 4'h0);
wire last_bit = (bits_left_r == 4'h1);
wire shift_done = shift_empty | last_bit;
wire load_now = tx_active & rise_tick & shift_done & holding_full_r;
wire shift_now = tx_active & rise_tick & ~shift_done;
wire end_now = tx_active & rise_tick & last_bit & ~holding_full_r;
wire hold_write = reg_wr & (reg_addr == `ADDR_TX_HOLDING);
wire rx_sample = master & receiving & ~transmit_enable_r & fall_tick;
wire [3:0] rx_bits = 4'h8;
// ----------------------------------------
// baud generator
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        baud_cnt_r <= 8'h00;
        phase_r <= 1'b0;
    end
    else if (!baud_run)
    begin
        baud_cnt_r <= 8'h00;
        phase_r <= 1'b0;
    end
    else if (baud_cnt_r == 8'h00)
    begin
        baud_cnt_r <= baud_divisor_r;
        phase_r <= ~phase_r;
    end
    else
    begin
        baud_cnt_r <= baud_cnt_r - 8'h01;
    end
end
// ----------------------------------------
// control registers and bus
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        clock_source_select_r <= 1'b0;
        ninth_bit_transmit_select_r <= 1'b0;
        transmit_enable_r <= 1'b0;
        sync_mode_r <= 1'b0;
        ninth_transmit_bit_value_r <= 1'b0;
        serial_port_enable_r <= 1'b0;
        single_receive_enable_r <= 1'b0;
        continuous_receive_enable_r <= 1'b0;
        baud_divisor_r <= `RST_BAUD_DIVISOR;
        transmit_interrupt_enable_r <= 1'b0;
        reg_rdata <= 8'h00;
    end
    else
    begin
        if (reg_wr && reg_addr == `ADDR_TX_STATUS_CONTROL)
        begin
            clock_source_select_r <= reg_wdata[`TXC_CLOCK_SOURCE];
            ninth_bit_transmit_select_r <= reg_wdata[`TXC_NINTH_SELECT];
            transmit_enable_r <= reg_wdata[`TXC_TX_ENABLE];
            sync_mode_r <= reg_wdata[`TXC_SYNC_MODE];
            ninth_transmit_bit_value_r <= reg_wdata[`TXC_NINTH_VALUE];
        end
        if (reg_wr && reg_addr == `ADDR_RX_STATUS_CONTROL)
        begin
            serial_port_enable_r <= reg_wdata[`RXC_PORT_ENABLE];
            single_receive_enable_r <= reg_wdata[`RXC_SINGLE_RX];
            continuous_receive_enable_r <= reg_wdata[`RXC_CONT_RX];
        end
        else if (rx_sample && rx_count_r == rx_bits - 4'h1)
        begin
            single_receive_enable_r <= 1'b0;
        end
        if (reg_wr && reg_addr == `ADDR_BAUD_DIVISOR)
        begin
            baud_divisor_r <= reg_wdata;
        end
        if (reg_wr && reg_addr == `ADDR_IRQ_ENABLE)
        begin
            transmit_interrupt_enable_r <= reg_wdata[`IRQ_TX_FLAG];
        end
        reg_rdata <= 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_TX_STATUS_CONTROL:
                    reg_rdata <= {clock_source_select_r, ninth_bit_transmit_select_r, transmit_enable_r,
                                  sync_mode_r, 2'b00, shift_empty, ninth_transmit_bit_value_r};
                `ADDR_RX_STATUS_CONTROL:
                    reg_rdata <= {serial_port_enable_r, 1'b0, single_receive_enable_r,
                                  continuous_receive_enable_r, 4'h0};
                `ADDR_BAUD_DIVISOR:
                    reg_rdata <= baud_divisor_r;
                `ADDR_IRQ_FLAG:
                    reg_rdata <= {6'h00, ~holding_full_r, rx_flag_r};
                `ADDR_IRQ_ENABLE:
                    reg_rdata <= {6'h00, transmit_interrupt_enable_r, 1'b0};
                `ADDR_RX_DATA:
                    reg_rdata <= rx_data_r;
                default:
                    reg_rdata <= 8'h00; // holding buffer and shift register read as zero
            endcase
        end
    end
end
// ----------------------------------------
// transmit holding buffer
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        transmit_holding_buffer_r <= 8'h00;
        holding_full_r <= 1'b0;
    end
    else
    begin
        // flag is empty buffer: a write clears it, transfer sets it
        if (hold_write)
        begin
            transmit_holding_buffer_r <= reg_wdata;
            holding_full_r <= 1'b1;
        end
        else if (load_now)
        begin
            holding_full_r <= 1'b0;
        end
    end
end
// ----------------------------------------
// transmit shift register
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        transmit_shift_register_r <= 9'h000;
        bits_left_r <= 4'h0;
    end
    else if (tx_reset)
    begin
        bits_left_r <= 4'h0;
    end
    else if (load_now)
    begin
        transmit_shift_register_r <= {ninth_transmit_bit_value_r, transmit_holding_buffer_r};
        bits_left_r <= ninth_bit_transmit_select_r ? 4'h9 : 4'h8;
    end
    else if (shift_now)
    begin
        transmit_shift_register_r <= {1'b0, transmit_shift_register_r[8:1]};
        bits_left_r <= bits_left_r - 4'h1;
    end
    else if (end_now)
    begin
        bits_left_r <= 4'h0; // last bit done with nothing waiting
    end
end
// ----------------------------------------
// receive path for half-duplex interplay
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        rx_shift_r <= 8'h00;
        rx_count_r <= 4'h0;
        rx_data_r <= 8'h00;
        rx_flag_r <= 1'b0;
    end
    else
    begin
        if (!receiving)
        begin
            rx_count_r <= 4'h0;
        end
        else if (rx_sample)
        begin
            rx_shift_r <= {data_sync, rx_shift_r[7:1]};
            rx_count_r <= (rx_count_r == rx_bits - 4'h1) ? 4'h0 : rx_count_r + 4'h1;
        end
        if (rx_sample && rx_count_r == rx_bits - 4'h1)
        begin
            rx_data_r <= {data_sync, rx_shift_r[7:1]};
            rx_flag_r <= 1'b1;
        end
        else if (reg_rd && reg_addr == `ADDR_RX_DATA)
        begin
            rx_flag_r <= 1'b0;
        end
    end
end
// ----------------------------------------
// clock pin drive
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        shift_strobe_line_out <= 1'b1;
        shift_strobe_line_oe <= 1'b0;
    end
    else
    begin
        shift_strobe_line_oe <= master & baud_run & (transmit_enable_r | receiving);
        // starts high like the idle line, so the first tick is a falling edge
        shift_strobe_line_out <= baud_run ? ~phase_r : clk_sync;
    end
end
// ----------------------------------------
// data pin drive
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        serial_data_line_out <= 1'b0;
        serial_data_line_oe <= 1'b0;
    end
    else
    begin
        // data drive follows transmit state; it updates on the rising clock phase
        serial_data_line_oe <= tx_active;
        if (load_now)
        begin
            serial_data_line_out <= transmit_holding_buffer_r[0];
        end
        else if (shift_now)
        begin
            serial_data_line_out <= transmit_shift_register_r[1];
        end
    end
end
// ----------------------------------------
// transmit request
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        transmit_irq_request <= 1'b0;
    end
    else
    begin
        transmit_irq_request <= ~holding_full_r & transmit_interrupt_enable_r;
    end
end
endmodule
`default_nettype wire

//--- verif/usart_sync_master_tx_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_tx_regs.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module usart_tx_checker
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic shift_strobe_line_out,
    input wire logic shift_strobe_line_oe,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    input wire logic transmit_irq_request
);
    reg [7:0] tx_r;
    reg [7:0] rx_r;
    reg ie_r;
    wire cont_on = rx_r[4];
    wire idle_all = !tx_r[5] && !cont_on && !rx_r[5];
    wire master_on = rx_r[7] && tx_r[7] && tx_r[4];
    wire hold_wr = reg_wr && reg_addr == `ADDR_TX_HOLDING;
    // shadow of the control bits seen on the register port
    always @(posedge core_clk or negedge reset_n)
        if (!reset_n)
        begin
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            ie_r <= 1'b0;
        end
        else if (reg_wr && reg_addr == `ADDR_TX_STATUS_CONTROL)
            tx_r <= reg_wdata;
        else if (reg_wr && reg_addr == `ADDR_RX_STATUS_CONTROL)
            rx_r <= reg_wdata;
        else if (reg_wr && reg_addr == `ADDR_IRQ_ENABLE)
            ie_r <= reg_wdata[1];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    AST_STOP_FLOAT: assert property (idle_all[*3] |-> !shift_strobe_line_oe && !serial_data_line_oe)
        else $error("pins driven while link stopped");
    AST_RX_BLOCKS_TX: assert property (cont_on[*3] |-> !serial_data_line_oe)
        else $error("data driven while receiving");
    AST_RX_KEEPS_CLK: assert property ((cont_on && master_on)[*3] |-> shift_strobe_line_oe)
        else $error("master clock released while receiving");
    AST_PORT_OFF: assert property (!rx_r[7][*3] |-> !shift_strobe_line_oe && !serial_data_line_oe)
        else $error("pins driven with port off");
    AST_DATA_STEADY: assert property ($fell(shift_strobe_line_out) && serial_data_line_oe |->
        $stable(serial_data_line_out)) else $error("data moved at falling clock");
    AST_GEN_HELD: assert property (idle_all[*8] |-> $stable(shift_strobe_line_out))
        else $error("clock toggles with generator held");
    AST_IRQ_GATED: assert property (!ie_r[*2] |-> !transmit_irq_request)
        else $error("request without enable");
    AST_WRITE_CLEARS: assert property (hold_wr && ie_r |-> ##[1:2] !transmit_irq_request)
        else $error("flag kept after buffer write");
    AST_HOLD_HIDDEN: assert property (reg_rd && reg_addr == `ADDR_TX_HOLDING |=> reg_rdata == 8'h00)
        else $error("holding buffer readable");
    cover property ($fell(shift_strobe_line_out) && serial_data_line_oe);
    cover property (cont_on && tx_r[5] && master_on);
    cover property (hold_wr && !transmit_irq_request);
endmodule
bind usart_sync_master_tx usart_tx_checker usart_tx_checker_inst
(
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shift_strobe_line_out, .shift_strobe_line_oe, .serial_data_line_out,
    .serial_data_line_oe, .transmit_irq_request
);
`default_nettype wire

//--- verif/link_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// slave on clock and data lines
// ----------------------------------------
module link_slave_model
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic data_driven,
    output var logic drive_bit
);
    bit bits[$];
    logic clk_d_r;
    always @(posedge core_clk or negedge reset_n)
        if (!reset_n)
        begin
            clk_d_r <= 1'b1;
            drive_bit <= 1'b0;
        end
        else
        begin
            clk_d_r <= link_clk;
            // released data line shows a changing pattern
            drive_bit <= ~drive_bit;
            if (clk_d_r && !link_clk && data_driven)
                bits.push_back(link_data);
        end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_tx_regs.vh"
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
    logic core_clk;
    logic reset_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    wire [7:0] reg_rdata;
    wire ck_o;
    wire ck_oe;
    wire dt_o;
    wire dt_oe;
    wire irq;
    wire slave_bit;
    // clock line has a pull-up
    wire ck_pin = ck_oe ? ck_o : 1'b1;
    wire dt_pin = dt_oe ? dt_o : slave_bit;
    int fail_count = 0;
    int checks = 0;
    int seed = 32'h3551;
    logic [31:0] d;
    bit model_q[$];
    logic [7:0] raddr[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h7F};
    logic [7:0] rexp[6] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    usart_sync_master_tx usart_sync_master_tx_inst
    (
        .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .shift_strobe_line_in(ck_pin), .shift_strobe_line_out(ck_o), .shift_strobe_line_oe(ck_oe),
        .serial_data_line_in(dt_pin), .serial_data_line_out(dt_o), .serial_data_line_oe(dt_oe),
        .transmit_irq_request(irq)
    );
    link_slave_model link_slave_model_inst
    (
        .core_clk, .reset_n, .link_clk(ck_pin), .link_data(dt_pin), .data_driven(dt_oe),
        .drive_bit(slave_bit)
    );
    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk({1'b0, reg_rdata}, {1'b0, e});
        @(posedge core_clk);
    endtask
    task automatic expect_word(input logic [7:0] v, input logic n9, input logic nine);
        for (int i = 0; i < 8; i++)
            model_q.push_back(v[i]);
        if (nine)
            model_q.push_back(n9);
    endtask
    task automatic send(input logic [7:0] v, input logic n9, input logic nine);
        wr(`ADDR_TX_STATUS_CONTROL, {1'b1, nine, 5'b11000, n9});
        wr(`ADDR_TX_HOLDING, v);
        expect_word(v, n9, nine);
    endtask
    // waits for a buffer transfer, then starts a fresh capture
    task automatic wait_irq();
        int i;
        i = 0;
        @(posedge core_clk);
        while (irq !== 1'b1 && i < 2000)
        begin
            @(posedge core_clk);
            i++;
        end
        if (i == 2000)
        begin
            fail_count++;
            tally_and_finish();
        end
        link_slave_model_inst.bits.delete();
    endtask
    task automatic drain();
        int i;
        i = 0;
        while (link_slave_model_inst.bits.size() < model_q.size() && i < 2000)
        begin
            @(posedge core_clk);
            i++;
        end
        if (i == 2000)
        begin
            fail_count++;
            tally_and_finish();
        end
        while (model_q.size() > 0)
            chk({8'h00, link_slave_model_inst.bits.pop_front()}, {8'h00, model_q.pop_front()});
    endtask
    task automatic pins(input logic [8:0] e);
        repeat (3) @(posedge core_clk);
        chk({7'h00, ck_oe, dt_oe}, e);
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial
    begin
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        foreach (raddr[i])
            rd(raddr[i], rexp[i]);
        wr(`ADDR_BAUD_DIVISOR, 8'h13);
        wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
        wr(`ADDR_TX_STATUS_CONTROL, 8'h90);
        wr(`ADDR_IRQ_FLAG, 8'h00);
        rd(`ADDR_IRQ_FLAG, 8'h02);
        chk({8'h00, irq}, 9'h000);
        wr(`ADDR_IRQ_ENABLE, 8'h02);
        #1 chk({8'h00, irq}, 9'h001);
        d = $random(seed);
        wr(`ADDR_TX_HOLDING, d[7:0]);
        #1 chk({8'h00, irq}, 9'h000);
        rd(`ADDR_IRQ_FLAG, 8'h00);
        expect_word(d[7:0], 1'b0, 1'b0);
        wr(`ADDR_TX_STATUS_CONTROL, 8'hB0);
        wait_irq();
        drain();
        repeat (48) @(posedge core_clk);
        rd(`ADDR_TX_STATUS_CONTROL, 8'hB2);
        rd(`ADDR_IRQ_FLAG, 8'h02);
        repeat (3)
        begin
            d = $random(seed);
            send(d[7:0], d[8], 1'b1);
            wait_irq();
            send(d[16:9], d[17], 1'b1);
            drain();
        end
        d = $random(seed);
        send(d[7:0], 1'b0, 1'b0);
        wait_irq();
        repeat (60) @(posedge core_clk);
        wr(`ADDR_RX_STATUS_CONTROL, 8'h90);
        pins(9'h002);
        wr(`ADDR_TX_STATUS_CONTROL, 8'h90);
        wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
        pins(9'h000);
        model_q.delete();
        send(d[15:8], 1'b0, 1'b0);
        wait_irq();
        repeat (60) @(posedge core_clk);
        wr(`ADDR_RX_STATUS_CONTROL, 8'h00);
        pins(9'h000);
        wr(`ADDR_RX_STATUS_CONTROL, 8'h80);
        model_q.delete();
        send(d[23:16], 1'b0, 1'b0);
        wait_irq();
        drain();
        tally_and_finish();
    end
endmodule
`default_nettype wire
